// >>> pkg/dl_irq_defines.svh
`ifndef DL_IRQ_DEFINES_SVH
`define DL_IRQ_DEFINES_SVH

// Register offsets within the channel's register page
`define STATUS_OFFSET      8'h06
`define ENABLE_OFFSET      8'h07

// Bit positions of the status register; bits 6..0 are shared by the enable register
`define BIT_MSG_TYPE       7
`define BIT_TX_BEGIN       6
`define BIT_RX_BEGIN       5
`define BIT_TX_END         4
`define BIT_RX_END         3
`define BIT_FCS            2
`define BIT_ABORT          1
`define BIT_IDLE           0

`define STATUS_RESET       8'h00
`define ENABLE_RESET       8'h00
`define ENABLE_WMASK       8'h7F

`endif

// >>> pkg/dl_irq_pkg.sv
package dl_irq_pkg;

  // One-cycle event pulses from the link controllers
  typedef struct packed {
    logic tx_begin;
    logic rx_begin;
    logic tx_end;
    logic rx_message_done;
    logic rx_buffer_full;
    logic fcs_mismatch;
    logic abort_seen;
    logic idle_octet_seen;
  } link_events_t;

  // Microprocessor register port request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// >>> hdl/data_link_irq_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "dl_irq_defines.svh"

module data_link_irq_flags (
  input  wire logic                     MCLK,
  input  wire logic                     RST_N,
  input  wire dl_irq_pkg::link_events_t EVENTS,
  input  wire logic                     MSG_ORIENTED,
  input  wire dl_irq_pkg::reg_req_t     REQ,
  output logic [7:0]                    RDATA,
  output logic                          IRQ
);
  import dl_irq_pkg::*;

  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] enable_reg;
  logic [7:0] enable_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       irq_reg;
  logic       irq_next;
  logic [7:0] set_vec;
  logic       status_rd;
  logic       enable_wr;
  logic       enable_rd;

  assign status_rd = REQ.rd && (REQ.addr == `STATUS_OFFSET);
  assign enable_wr = REQ.wr && (REQ.addr == `ENABLE_OFFSET);
  assign enable_rd = REQ.rd && (REQ.addr == `ENABLE_OFFSET);

  always_comb begin
    set_vec = 8'h00;
    set_vec[`BIT_TX_BEGIN] = EVENTS.tx_begin;
    set_vec[`BIT_RX_BEGIN] = EVENTS.rx_begin;
    set_vec[`BIT_TX_END] = EVENTS.tx_end;
    set_vec[`BIT_RX_END] = EVENTS.rx_message_done | EVENTS.rx_buffer_full;
    set_vec[`BIT_FCS] = EVENTS.fcs_mismatch;
    set_vec[`BIT_ABORT] = EVENTS.abort_seen;
    set_vec[`BIT_IDLE] = EVENTS.idle_octet_seen;
  end

  always_comb begin
    status_next = (status_rd ? `STATUS_RESET : status_reg) | set_vec;
    // Bit 7 is the live message type, never stored
    status_next[`BIT_MSG_TYPE] = 1'b0;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= `STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_comb begin
    enable_next = enable_wr ? (REQ.wdata & `ENABLE_WMASK) : enable_reg;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_reg <= `ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (REQ.rd) begin
      case (REQ.addr)
        `STATUS_OFFSET: rdata_next = {MSG_ORIENTED, status_reg[6:0]};
        `ENABLE_OFFSET: rdata_next = enable_reg;
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // gated request, same edge as the flags
  always_comb begin
    irq_next = |(status_next[6:0] & enable_next[6:0]);
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign RDATA = rdata_reg;
  assign IRQ   = irq_reg;

  a_read_clears: assert property (@(posedge MCLK) disable iff (!RST_N)
    status_rd && !EVENTS.abort_seen |=> !status_reg[`BIT_ABORT])
    else $error("status not cleared by read");
  a_set_wins: assert property (@(posedge MCLK) disable iff (!RST_N)
    status_rd && EVENTS.idle_octet_seen |=> status_reg[`BIT_IDLE])
    else $error("event lost during read");
  a_end_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.rx_buffer_full |=> status_reg[`BIT_RX_END])
    else $error("buffer full did not set end flag");
  a_fcs_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.fcs_mismatch |=> status_reg[`BIT_FCS])
    else $error("fcs flag not set");
  a_abort_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.abort_seen |=> status_reg[`BIT_ABORT])
    else $error("abort flag not set");
  a_idle_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.idle_octet_seen |=> status_reg[`BIT_IDLE])
    else $error("idle flag not set");
  a_both_read: assert property (@(posedge MCLK) disable iff (!RST_N)
    status_rd && status_reg[0] && status_reg[3] |=> RDATA[0] && RDATA[3])
    else $error("idle and end not reported together");
  a_tx_begin: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.tx_begin |=> status_reg[`BIT_TX_BEGIN])
    else $error("tx begin flag not set");
  a_rx_begin: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.rx_begin |=> status_reg[`BIT_RX_BEGIN])
    else $error("rx begin flag not set");
  a_tx_end: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.tx_end |=> status_reg[`BIT_TX_END])
    else $error("tx end flag not set");
  a_enable_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    enable_wr |=> enable_reg == ($past(REQ.wdata) & `ENABLE_WMASK))
    else $error("enable write not stored");
  a_irq_release: assert property (@(posedge MCLK) disable iff (!RST_N)
    status_rd && !enable_wr && (EVENTS == '0) |=> !IRQ)
    else $error("request not released after read");
  a_irq_blocked: assert property (@(posedge MCLK) disable iff (!RST_N)
    enable_reg == 8'h00 && !enable_wr |=> !IRQ)
    else $error("request with all enables off");

  a_msg_done_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.rx_message_done |=> status_reg[`BIT_RX_END])
    else $error("message done did not set end flag");

  a_tx_begin_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.tx_begin && enable_reg[`BIT_TX_BEGIN] && !enable_wr |=> IRQ)
    else $error("enabled tx begin gave no request");

  a_rx_begin_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.rx_begin && enable_reg[`BIT_RX_BEGIN] && !enable_wr |=> IRQ)
    else $error("enabled rx begin gave no request");

  a_tx_end_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.tx_end && enable_reg[`BIT_TX_END] && !enable_wr |=> IRQ)
    else $error("enabled tx end gave no request");

  a_rx_end_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.rx_message_done && enable_reg[`BIT_RX_END] && !enable_wr |=> IRQ)
    else $error("enabled rx end gave no request");

  a_fcs_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.fcs_mismatch && enable_reg[`BIT_FCS] && !enable_wr |=> IRQ)
    else $error("enabled fcs event gave no request");

  a_abort_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.abort_seen && enable_reg[`BIT_ABORT] && !enable_wr |=> IRQ)
    else $error("enabled abort event gave no request");

  a_idle_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    EVENTS.idle_octet_seen && enable_reg[`BIT_IDLE] && !enable_wr |=> IRQ)
    else $error("enabled idle event gave no request");

  a_enable_read: assert property (@(posedge MCLK) disable iff (!RST_N)
    enable_rd |=> !RDATA[`BIT_MSG_TYPE])
    else $error("reserved enable bit read as one");

  a_type_live: assert property (@(posedge MCLK) disable iff (!RST_N)
    status_rd |=> RDATA[`BIT_MSG_TYPE] == $past(MSG_ORIENTED))
    else $error("message type bit not live");

  a_rdata_idle: assert property (@(posedge MCLK) disable iff (!RST_N)
    !REQ.rd |=> RDATA == 8'h00)
    else $error("read data without a read");

  a_status_ro: assert property (@(posedge MCLK) disable iff (!RST_N)
    REQ.wr && !REQ.rd && (REQ.addr == `STATUS_OFFSET) && (set_vec == 8'h00)
    |=> status_reg == $past(status_reg))
    else $error("status changed by a write");

  // Every event flag stays until software reads it
  for (genvar b = 0; b < 7; b++) begin : g_flag_hold
    a_flag_holds: assert property (@(posedge MCLK) disable iff (!RST_N)
      status_reg[b] && !status_rd |=> status_reg[b])
      else $error("status flag dropped without a read");
  end

endmodule

`default_nettype wire

// >>> tb/data_link_hdlc_interrupt_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dl_irq_defines.svh"

module data_link_hdlc_interrupt_flags_bench;
  import dl_irq_pkg::*;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  link_events_t ev = '0;
  logic         msg_oriented = 1'b0;
  reg_req_t     req = '0;
  logic [7:0]   rdata;
  logic         irq;
  logic [7:0]   want;
  int           error_cnt = 0;
  int           total_checks = 0;

  always #25 mclk = ~mclk;

  data_link_irq_flags i_dut (
    .MCLK(mclk), .RST_N(rst_n), .EVENTS(ev), .MSG_ORIENTED(msg_oriented),
    .REQ(req), .RDATA(rdata), .IRQ(irq));

  task automatic check(input logic [7:0] got, input logic [7:0] exp_val);
    total_checks++;
    if (got !== exp_val) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp_val);
    end
  endtask

  // One register cycle; read data is settled at the closing falling edge
  task automatic access(input logic rd, input logic wr, input logic [7:0] addr,
                        input logic [7:0] wdata);
    @(negedge mclk);
    req <= '{rd, wr, addr, wdata};
    @(negedge mclk);
    req <= '0;
  endtask

  task automatic pulse(input logic [7:0] bits);
    @(negedge mclk);
    ev <= link_events_t'(bits);
    @(negedge mclk);
    ev <= '0;
  endtask

  // Status read with events landing on the same edge
  task automatic read_during(input logic [7:0] bits);
    @(negedge mclk);
    req <= '{1'b1, 1'b0, `STATUS_OFFSET, 8'h00};
    ev  <= link_events_t'(bits);
    @(negedge mclk);
    req <= '0;
    ev  <= '0;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    access(1'b1, 1'b0, `STATUS_OFFSET, 8'h00);
    check(rdata, 8'h00);
    access(1'b1, 1'b0, `ENABLE_OFFSET, 8'h00);
    check(rdata, 8'h00);
    // All events with every enable off; a status write must not clear them
    pulse(8'hFF);
    check({7'h00, irq}, 8'h00);
    access(1'b0, 1'b1, `STATUS_OFFSET, 8'h00);
    access(1'b1, 1'b0, `STATUS_OFFSET, 8'h00);
    check(rdata, 8'h7F);
    access(1'b0, 1'b1, `ENABLE_OFFSET, 8'hFF);
    access(1'b1, 1'b0, `ENABLE_OFFSET, 8'h00);
    check(rdata, 8'h7F);
    access(1'b1, 1'b0, 8'h08, 8'h00);
    check(rdata, 8'h00);
    // All events with every enable on
    pulse(8'hFF);
    check({7'h00, irq}, 8'h01);
    access(1'b1, 1'b0, `STATUS_OFFSET, 8'h00);
    check(rdata, 8'h7F);
    check({7'h00, irq}, 8'h00);
    // An event on the read edge survives the clear
    pulse(8'h02);
    read_during(8'h01);
    check(rdata, 8'h02);
    check({7'h00, irq}, 8'h01);
    access(1'b1, 1'b0, `STATUS_OFFSET, 8'h00);
    check(rdata, 8'h01);
    // Each event alone: masked, then unmasked, then read-cleared
    for (int i = 0; i < 8; i++) begin
      want = (i > 3) ? (8'h01 << (i - 1)) : (8'h01 << i);
      access(1'b0, 1'b1, `ENABLE_OFFSET, ~want & 8'h7F);
      pulse(8'h01 << i);
      check({7'h00, irq}, 8'h00);
      access(1'b0, 1'b1, `ENABLE_OFFSET, want);
      @(negedge mclk);
      check({7'h00, irq}, 8'h01);
      access(1'b1, 1'b0, `STATUS_OFFSET, 8'h00);
      check(rdata, want);
      check({7'h00, irq}, 8'h00);
      access(1'b1, 1'b0, `STATUS_OFFSET, 8'h00);
      check(rdata, 8'h00);
    end
    pulse(8'h11);
    msg_oriented = 1'b1;
    access(1'b1, 1'b0, `STATUS_OFFSET, 8'h00);
    check(rdata, 8'h89);
    give_verdict();
  end

  initial begin
    #50us;
    error_cnt++;
    give_verdict();
  end
endmodule

`default_nettype wire
